// >>> dcs_chain_config.sv
`default_nettype none
module dcs_chain_config
  import dcs_pkg::*;
#(
  parameter int HAS_EXTRA_SELECTS = 1
)(
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic             HOST_SELECT_N,
  input  wire logic             HOST_CLOCK,
  input  wire logic             HOST_DATA_IN,
  output logic                  HOST_DATA_OUT,
  output logic                  HOST_DATA_OUT_EN,
  input  wire logic             STEP_DIR_MODE,
  input  wire logic             CHAIN_START,
  input  wire dcs_word_type [2:0] CHAIN_WORDS,
  output logic                  CHAIN_SELECT,
  output logic                  SECOND_DRIVER_SELECT,
  output logic                  THIRD_DRIVER_SELECT,
  output logic                  CHAIN_CLOCK,
  output logic                  CHAIN_DATA,
  output logic                  CHAIN_BUSY,
  output logic [23:0]           CONFIG_OUT
);
  if (HAS_EXTRA_SELECTS != 0 && HAS_EXTRA_SELECTS != 1)
  begin : g_check
    $error("HAS_EXTRA_SELECTS must be 0 or 1");
  end

  logic [1:0]    rst_sync;
  logic          rst_n;
  dcs_state_type s;
  dcs_state_type n;
  logic          spi;
  logic          indiv;
  logic          hrise;
  logic          hfall;
  logic [31:0]   frame;
  logic [7:0]    div;
  logic [7:0]    lo_end;
  logic [7:0]    half_end;
  logic [1:0]    last;
  logic          active;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Encodes one driver word with the polarity settings applied.
  function automatic logic [8:0] dcs_encode(input dcs_word_type w, input logic [23:0] c);
    dcs_word_type e;
    e = w;
    e.phase = w.phase ^ {2{c[DCS_POL_PHASE]}};
    e.decay = w.decay ^ c[DCS_POL_DECAY];
    e.level_a = w.level_a ^ {3{c[DCS_POL_LEVEL]}};
    e.level_b = w.level_b ^ {3{c[DCS_POL_LEVEL]}};
    return e;
  endfunction : dcs_encode

  always_comb
  begin
    n = s;
    spi = !STEP_DIR_MODE;
    indiv = s.setup[DCS_SCHEME] && (HAS_EXTRA_SELECTS == 1);
    hrise = HOST_CLOCK && !s.host_clk_q;
    hfall = !HOST_CLOCK && s.host_clk_q;
    frame = {s.rx[30:0], HOST_DATA_IN};
    div = s.setup[DCS_DIV_LSB +: 8];
    lo_end = (div < DCS_DIV_MIN) ? (DCS_MIN_PERIOD_END - div) : div;
    half_end = s.sck ? div : lo_end;
    last = (s.setup[DCS_COUNT_LSB +: 2] == DCS_COUNT_BAD) ? DCS_COUNT_MAX : s.setup[DCS_COUNT_LSB +: 2];
    n.host_clk_q = HOST_CLOCK;
    if (HOST_SELECT_N)
    begin
      n.rx_count = 6'h0;
      n.reply = 24'h0;
    end
    else
    begin
      if (hrise)
      begin
        n.rx = frame;
        n.rx_count = s.rx_count + 6'h1;
        if (s.rx_count == 6'(DCS_HEADER_END))
        begin
          if (frame[7] == DCS_SPACE_CONFIG && frame[6:1] == DCS_GLOBAL_ADDR && frame[0])
            n.reply = s.setup;
          else
            n.reply = 24'h0;
        end
        if (s.rx_count == 6'(DCS_LAST_BIT) && frame[31] == DCS_SPACE_CONFIG
            && frame[30:25] == DCS_GLOBAL_ADDR && !frame[24])
          n.setup = frame[23:0];
      end
      if (hfall && s.rx_count > 6'(DCS_HEADER_END + 1))
        n.reply = {s.reply[22:0], 1'b0};
    end
    case (s.phase)
      DCS_IDLE:
      begin
        if (CHAIN_START && spi)
        begin
          n.phase = DCS_SHIFT;
          n.driver = last;
          n.tx = dcs_encode(CHAIN_WORDS[last], s.setup);
          n.bit_left = DCS_WORD_LAST;
          n.half = 8'h0;
          n.sck = 1'b0;
          n.select_on = 1'b1;
        end
      end
      DCS_SHIFT:
      begin
        n.half = s.half + 8'h1;
        if (s.half == half_end)
        begin
          n.half = 8'h0;
          n.sck = !s.sck;
          if (s.sck)
          begin
            n.tx = {s.tx[7:0], 1'b0};
            n.bit_left = s.bit_left - 4'h1;
            if (s.bit_left == 4'h0)
            begin
              if (s.driver == 2'h0)
              begin
                n.phase = DCS_IDLE;
                n.select_on = 1'b0;
              end
              else
              begin
                n.driver = s.driver - 2'h1;
                n.tx = dcs_encode(CHAIN_WORDS[s.driver - 2'h1], s.setup);
                n.bit_left = DCS_WORD_LAST;
                if (indiv)
                begin
                  n.phase = DCS_GAP;
                  n.select_on = 1'b0;
                end
              end
            end
          end
        end
      end
      DCS_GAP:
      begin
        n.half = s.half + 8'h1;
        if (s.half == lo_end)
        begin
          n.half = 8'h0;
          n.phase = DCS_SHIFT;
          n.select_on = 1'b1;
        end
      end
      default:
      begin
        n.phase = DCS_IDLE;
        n.select_on = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      s <= DCS_STATE_RESET;
    else
      s <= n;
  end

  assign active = s.select_on && (!indiv || s.driver == 2'h0);
  assign CHAIN_SELECT = !spi || (indiv ? !active : (active ^ !s.setup[DCS_POL_SELECT]));
  assign SECOND_DRIVER_SELECT = !(spi && indiv && s.select_on && s.driver == 2'h1);
  assign THIRD_DRIVER_SELECT = !(spi && indiv && s.select_on && s.driver == 2'h2);
  assign CHAIN_CLOCK = spi && (s.sck ^ s.setup[DCS_POL_CLOCK]);
  assign CHAIN_DATA = spi && s.tx[8] && s.phase == DCS_SHIFT;
  assign CHAIN_BUSY = s.phase != DCS_IDLE;
  assign CONFIG_OUT = s.setup;
  assign HOST_DATA_OUT = s.reply[23];
  assign HOST_DATA_OUT_EN = !HOST_SELECT_N;

  // Counts the cycles of the current clock half; it restarts on every toggle and outside shifting.
  logic [7:0] run_len;
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      run_len <= 8'h0;
    else if (n.sck != s.sck || s.phase != DCS_SHIFT)
      run_len <= 8'h0;
    else
      run_len <= run_len + 8'h1;
  end

  sel_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_IDLE && spi && !indiv) |-> CHAIN_SELECT == !s.setup[DCS_POL_SELECT])
    else $error("Idle chain select has wrong level.");
  start_sel_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_IDLE && CHAIN_START && spi && !indiv) |=> CHAIN_SELECT == s.setup[DCS_POL_SELECT])
    else $error("Common select not active at start.");
  busy_sel_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_SHIFT && spi && !indiv) |-> CHAIN_SELECT == s.setup[DCS_POL_SELECT])
    else $error("Common select dropped during shifting.");
  extra_off_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !indiv |-> (SECOND_DRIVER_SELECT && THIRD_DRIVER_SELECT))
    else $error("Extra select active in common mode.");
  gap_quiet_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_GAP && indiv) |-> (CHAIN_SELECT && SECOND_DRIVER_SELECT && THIRD_DRIVER_SELECT && !CHAIN_DATA))
    else $error("Select or data active between driver words.");
  clk_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase != DCS_SHIFT && spi) |-> CHAIN_CLOCK == s.setup[DCS_POL_CLOCK])
    else $error("Idle chain clock has wrong level.");
  first_bit_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_IDLE && CHAIN_START && spi) |=>
    CHAIN_DATA == ($past(CHAIN_WORDS[last].phase[1]) ^ s.setup[DCS_POL_PHASE]))
    else $error("First chain bit not phase with polarity.");
  one_select_a: assert property (@(posedge CLK) disable iff (!rst_n)
    indiv |-> $onehot0({!CHAIN_SELECT, !SECOND_DRIVER_SELECT, !THIRD_DRIVER_SELECT}))
    else $error("More than one individual select active.");
  div_reset_a: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(rst_n) |-> s.setup[DCS_DIV_LSB +: 8] == 8'h0f)
    else $error("Divider not fifteen after reset.");
  half_len_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ($past(s.phase) == DCS_SHIFT && s.sck != $past(s.sck) && $stable(s.setup) && div >= DCS_DIV_MIN)
    |-> $past(run_len) == div)
    else $error("Chain clock half period is not div+1.");
  div_min_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ($past(s.phase) == DCS_SHIFT && s.sck != $past(s.sck) && $stable(s.setup) && div == 8'h07)
    |-> $past(run_len) == 8'h07)
    else $error("Divider seven half period is not eight.");
  div_max_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ($past(s.phase) == DCS_SHIFT && s.sck != $past(s.sck) && $stable(s.setup) && div == 8'hff)
    |-> $past(run_len) == 8'hff)
    else $error("Divider 255 half period is wrong.");
  slow_clk_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ($past(s.phase) == DCS_SHIFT && s.sck && !$past(s.sck) && $stable(s.setup) && div < DCS_DIV_MIN)
    |-> $past(run_len) == 8'h0e - div)
    else $error("Low divider changed the clock period.");
  drv_count_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_IDLE && CHAIN_START && spi && s.setup[DCS_COUNT_LSB +: 2] != DCS_COUNT_BAD)
    |=> s.driver == $past(s.setup[DCS_COUNT_LSB +: 2]))
    else $error("First driver word does not match the count.");
  cfg_write_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (!HOST_SELECT_N && hrise && s.rx_count == 6'h1f && frame[31:24] == 8'hfe)
    |=> s.setup == $past(frame[23:0]))
    else $error("Write datagram did not load the register.");
  cfg_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !(!HOST_SELECT_N && hrise && s.rx_count == 6'h1f && frame[31:24] == 8'hfe)
    |=> $stable(s.setup))
    else $error("Register changed without a write datagram.");
  rd_reply_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (!HOST_SELECT_N && hrise && s.rx_count == 6'h07 && frame[7:0] == 8'hff)
    |=> HOST_DATA_OUT == $past(s.setup[23]))
    else $error("Read reply does not start with the top bit.");
  sd_start_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s.phase == DCS_IDLE && CHAIN_START && !spi) |=> !CHAIN_BUSY)
    else $error("Chain started in step/direction mode.");
  sd_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
    STEP_DIR_MODE |-> (CHAIN_SELECT && !CHAIN_CLOCK && !CHAIN_DATA))
    else $error("Chain pins moved in step/direction mode.");
endmodule : dcs_chain_config
`default_nettype wire

// >>> dcs_drv_model.sv
`default_nettype none
module dcs_drv_model
(
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        sel_on,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic [26:0]      got,
  output logic [5:0]       nbits,
  output logic [9:0]       period
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sck_q = 1'b0;
  logic [9:0] cnt   = 10'h0;
  // The chained chips shift in one bit on each rising edge while selected.
  always @(posedge clk)
  begin
    sck_q <= sck;
    cnt   <= cnt + 10'h1;
    if (clr)
    begin
      got   <= 27'h0;
      nbits <= 6'h0;
    end
    else if (sck && !sck_q && sel_on)
    begin
      got    <= {got[25:0], sdi};
      nbits  <= nbits + 6'h1;
      period <= cnt + 10'h1;
      cnt    <= 10'h0;
    end
  end
endmodule : dcs_drv_model
`default_nettype wire

// >>> dcs_pkg.sv
`default_nettype none
package dcs_pkg;
  localparam int          DCS_DATAGRAM_BITS  = 32;
  localparam int          DCS_DATA_BITS      = 24;
  localparam int          DCS_HEADER_END     = 7;
  localparam int          DCS_LAST_BIT       = 31;
  localparam logic        DCS_SPACE_CONFIG   = 1'b1;
  localparam logic [5:0]  DCS_GLOBAL_ADDR    = 6'h3f;
  localparam int          DCS_COUNT_LSB      = 0;
  localparam int          DCS_POL_SELECT     = 2;
  localparam int          DCS_POL_CLOCK      = 3;
  localparam int          DCS_POL_PHASE      = 4;
  localparam int          DCS_POL_DECAY      = 5;
  localparam int          DCS_POL_LEVEL      = 6;
  localparam int          DCS_SCHEME         = 7;
  localparam int          DCS_DIV_LSB        = 8;
  localparam logic [23:0] DCS_CONFIG_RESET   = 24'h000f00;
  localparam logic [7:0]  DCS_DIV_MIN        = 8'h07;
  localparam logic [7:0]  DCS_MIN_PERIOD_END = 8'h0e;
  localparam logic [1:0]  DCS_COUNT_BAD      = 2'h3;
  localparam logic [1:0]  DCS_COUNT_MAX      = 2'h2;
  localparam logic [3:0]  DCS_WORD_LAST      = 4'h8;

  typedef struct packed {
    logic [1:0] phase;
    logic       decay;
    logic [2:0] level_a;
    logic [2:0] level_b;
  } dcs_word_type;

  typedef enum logic [1:0] {DCS_IDLE, DCS_SHIFT, DCS_GAP} dcs_phase_type;

  typedef struct packed {
    logic [31:0]   rx;
    logic [5:0]    rx_count;
    logic          host_clk_q;
    logic [23:0]   reply;
    logic [23:0]   setup;
    dcs_phase_type phase;
    logic [1:0]    driver;
    logic [3:0]    bit_left;
    logic [7:0]    half;
    logic          sck;
    logic [8:0]    tx;
    logic          select_on;
  } dcs_state_type;

  localparam dcs_state_type DCS_STATE_RESET = '{
    rx: 32'h0, rx_count: 6'h0, host_clk_q: 1'b0, reply: 24'h0, setup: DCS_CONFIG_RESET,
    phase: DCS_IDLE, driver: 2'h0, bit_left: 4'h0, half: 8'h0, sck: 1'b0, tx: 9'h0,
    select_on: 1'b0};
endpackage : dcs_pkg
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
  import dcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk = 1'b0, rstn = 1'b0, hsel_n = 1'b1, hclk = 1'b0, hdin = 1'b0;
  logic               sdm = 1'b0, start = 1'b0, clr = 1'b1, pol_s = 1'b0, pol_c = 1'b0;
  logic               cs, cs2, cs3, sck, sdo, busy, hdo, hoe;
  logic [23:0]        cfg, r;
  logic [26:0]        got, e;
  logic [5:0]         nbits;
  logic [9:0]         per;
  logic [2:0]         first, m;
  logic [23:0]        rows [6] = '{24'h000700, 24'h00087d, 24'h000316, 24'h00ff20, 24'h070782, 24'h0a07c1};
  dcs_word_type [2:0] words = {9'h1c3, 9'h05a, 9'h1a5};
  int                 num_errors = 0, num_checks = 0, multi = 0, n;

  always #50 clk = ~clk;

  dcs_chain_config uut (.CLK(clk), .RESETN(rstn), .HOST_SELECT_N(hsel_n), .HOST_CLOCK(hclk),
    .HOST_DATA_IN(hdin), .HOST_DATA_OUT(hdo), .HOST_DATA_OUT_EN(hoe), .STEP_DIR_MODE(sdm),
    .CHAIN_START(start), .CHAIN_WORDS(words), .CHAIN_SELECT(cs), .SECOND_DRIVER_SELECT(cs2),
    .THIRD_DRIVER_SELECT(cs3), .CHAIN_CLOCK(sck), .CHAIN_DATA(sdo), .CHAIN_BUSY(busy), .CONFIG_OUT(cfg));

  dcs_drv_model drv (.clk(clk), .clr(clr), .sel_on(cs == pol_s || !cs2 || !cs3), .sck(sck ^ pol_c),
    .sdi(sdo), .got(got), .nbits(nbits), .period(per));

  // More than one select low at once is never allowed.
  always @(posedge clk)
    if (rstn && $countones(~{cs, cs2, cs3}) > 1)
      multi++;

  task tick(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : tick

  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task host(input logic [31:0] d, output logic [23:0] q);
    hsel_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      hdin = d[i];
      if (i < 24)
        q[i] = hdo;
      tick(1);
      hclk = 1'b1;
      tick(2);
      hclk = 1'b0;
      tick(1);
    end
    chk(hoe, 1'b1);
    hsel_n = 1'b1;
    tick(2);
    chk(hoe, 1'b0);
  endtask : host

  task run;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    start = 1'b1;
    tick(1);
    first = {cs, cs2, cs3};
    start = 1'b0;
    for (int k = 0; k < 6000 && busy !== 1'b0; k++)
      tick(1);
    chk(busy, 1'b0);
  endtask : run

  function automatic logic [8:0] enc(input dcs_word_type w, input logic [23:0] c);
    return {w.phase ^ {2{c[4]}}, w.decay ^ c[5], w.level_a ^ {3{c[6]}}, w.level_b ^ {3{c[6]}}};
  endfunction : enc

  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    #4000000;
    num_errors++;
    wrap_up;
  end

  initial
  begin
    tick(8);
    rstn = 1'b1;
    tick(3);
    chk(cfg, 24'h000f00);
    chk({busy, cs, cs2, cs3, sck}, 5'h0e);
    host({8'hff, 24'h0}, r);
    chk(r, 24'h000f00);
    // Individual rows keep the select polarity bit at zero.
    for (int i = 0; i < 6; i++)
    begin
      host({8'hfe, rows[i]}, r);
      chk(cfg, rows[i]);
      pol_s = rows[i][2];
      pol_c = rows[i][3];
      chk(sck, pol_c);
      n = rows[i][1:0] + 1;
      e = '0;
      for (int j = n - 1; j >= 0; j--)
        e = {e[17:0], enc(words[j], rows[i])};
      m = ~(3'b100 >> (n - 1));
      if (!rows[i][7])
        m = {pol_s, 2'b11};
      run;
      chk(first, m);
      chk(got, e);
      chk(nbits, 9 * n);
      chk(per, rows[i][15:8] < 8'h07 ? 16 : 2 * (rows[i][15:8] + 1));
    end
    chk(multi, 0);
    host({8'h7e, 24'h123456}, r);
    chk(cfg, rows[5]);
    host({8'hff, 24'h0}, r);
    chk(r, rows[5]);
    sdm = 1'b1;
    host({8'hfe, 24'h00077c}, r);
    run;
    chk({first, sck, nbits}, {3'b111, 1'b0, 6'h0});
    // A second reset after the step/direction run must bring the register back to its default.
    sdm = 1'b0;
    rstn = 1'b0;
    tick(2);
    chk(cfg, 24'h000f00);
    rstn = 1'b1;
    tick(3);
    host({8'hff, 24'h0}, r);
    chk(r, 24'h000f00);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
